// ===== rtl/fsr_slicer.sv
/*
 * FSK receive path: IF/ADC clock dividers, prefilter, decimating channel
 * filter, adaptive data slicer and bit synchronizer, with an 8-bit register port.
 * Assumes freq_est is a signed instantaneous-frequency sample centred on the IF,
 * synchronous to clk and qualified by sample_valid.
 */
`timescale 1ns/1ps
`include "fsr_params.svh"
module fsr_slicer (
    input wire logic clk,
    input wire logic reset,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic sample_valid,
    input wire fsr_pkg::fsr_sample_t freq_est,
    output logic pll_enable_a,
    output logic adc_clk,
    output logic if_clk,
    output logic prefilter_bypass,
    output logic rx_bit,
    output logic rx_clk,
    output fsr_pkg::fsr_sample_t avg_freq
);
    import fsr_pkg::*;

    logic [7:0] freq_word_low_byte_q;
    logic [7:0] modem_q;
    logic [7:0] filter_q;
    logic [7:0] frequency_tracking_ctrl_q;
    logic [15:0] baud_q;
    logic [7:0] rdata_q;

    // register decode
    wire logic wr_freq = wr_stb && (addr == `FSR_REG_FREQ_LOW);
    wire logic wr_modem = wr_stb && (addr == `FSR_REG_MODEM);
    wire logic wr_filter = wr_stb && (addr == `FSR_REG_FILTER);
    wire logic wr_track = wr_stb && (addr == `FSR_REG_TRACK);
    wire logic wr_baud_lo = wr_stb && (addr == `FSR_REG_BAUD_LO);
    wire logic wr_baud_hi = wr_stb && (addr == `FSR_REG_BAUD_HI);

    wire logic [2:0] adc_div = modem_q[2:0];
    wire logic [2:0] decimation_divider = filter_q[2:0];
    wire logic [1:0] expected_dev_exponent = frequency_tracking_ctrl_q[5:4];
    wire logic [3:0] expected_dev_mantissa = frequency_tracking_ctrl_q[3:0];
    wire logic [1:0] slicer_average_length = frequency_tracking_ctrl_q[7:6];

    always_ff @(posedge clk) begin
        if (reset) begin
            freq_word_low_byte_q <= `FSR_FREQ_LOW_RST;
            modem_q <= `FSR_MODEM_RST;
            filter_q <= `FSR_FILTER_RST;
            frequency_tracking_ctrl_q <= `FSR_TRACK_RST;
            baud_q <= `FSR_BAUD_RST;
        end else begin
            if (wr_freq) freq_word_low_byte_q <= wdata;
            if (wr_modem) modem_q <= wdata;
            if (wr_filter) filter_q <= wdata;
            if (wr_track) frequency_tracking_ctrl_q <= wdata;
            if (wr_baud_lo) baud_q[7:0] <= wdata;
            if (wr_baud_hi) baud_q[15:8] <= wdata;
        end
    end

    // pll_enable_a bit goes straight to the pll divider control
    assign pll_enable_a = freq_word_low_byte_q[`FSR_PLL_ENABLE_A_BIT];
    // the host owns the choice; the block just applies it
    assign prefilter_bypass = filter_q[`FSR_BYPASS_BIT];

    // adc clock = clk / (2(n+1)); if clock = adc / 4 = clk / (8(n+1))
    logic adc_tick;
    logic adc_clk_q;
    logic if_clk_q;
    logic [1:0] if_cnt_q;

    fsr_tick_div #(.W(3)) u_adc_div (
        .clk(clk),
        .reset(reset),
        .en(1'b1),
        .limit(adc_div),
        .tick(adc_tick)
    );

    wire logic if_edge = adc_tick && (if_cnt_q == `FSR_ADC_PER_IF);

    always_ff @(posedge clk) begin
        if (reset) begin
            adc_clk_q <= 1'b0;
            if_clk_q <= 1'b0;
            if_cnt_q <= 2'h0;
        end else begin
            if (adc_tick) adc_clk_q <= ~adc_clk_q;
            if (adc_tick) if_cnt_q <= if_cnt_q + 2'h1;
            if (if_edge) if_clk_q <= ~if_clk_q;
        end
    end
    assign adc_clk = adc_clk_q;
    assign if_clk = if_clk_q;

    // prefilter: two-tap average unless bypassed
    fsr_sample_t prev_q;
    wire logic signed [8:0] pair_sum = 9'(freq_est) + 9'(prev_q);
    wire fsr_sample_t pre_s = prefilter_bypass ? freq_est : pair_sum[8:1];

    // channel filter: box average over n+1 samples, narrowing bandwidth as n grows
    logic dec_tick;
    logic signed [10:0] acc_q;
    fsr_sample_t filt_q;
    logic filt_valid_q;

    fsr_tick_div #(.W(3)) u_decimation_divider (
        .clk(clk),
        .reset(reset),
        .en(sample_valid),
        .limit(decimation_divider),
        .tick(dec_tick)
    );

    // 256/(n+1), so the box sum scales back to one sample
    wire logic [8:0] recip = (decimation_divider == 3'h0) ? 9'h100 :
                             (decimation_divider == 3'h1) ? 9'h080 :
                             (decimation_divider == 3'h2) ? 9'h055 :
                             (decimation_divider == 3'h3) ? 9'h040 :
                             (decimation_divider == 3'h4) ? 9'h033 :
                             (decimation_divider == 3'h5) ? 9'h02b :
                             (decimation_divider == 3'h6) ? 9'h025 : 9'h020;
    wire logic signed [10:0] acc_sum = acc_q + 11'(pre_s);
    wire logic signed [20:0] scaled = acc_sum * $signed({1'b0, recip});

    always_ff @(posedge clk) begin
        if (reset) begin
            prev_q <= '0;
            acc_q <= '0;
            filt_q <= '0;
            filt_valid_q <= 1'b0;
        end else begin
            filt_valid_q <= sample_valid && dec_tick;
            if (sample_valid) begin
                prev_q <= freq_est;
                acc_q <= dec_tick ? 11'sh0 : acc_sum;
                if (dec_tick) filt_q <= scaled[15:8];
            end
        end
    end

    // slicer: track extremes on each side, swap side on a shift beyond deviation
    fsr_side_t side_q;
    fsr_sample_t ext_q;
    fsr_sample_t min_avg_q;
    fsr_sample_t max_avg_q;
    logic [1:0] trans_q;
    logic seeded_lo_q;
    logic seeded_hi_q;

    wire logic signed [9:0] dev = 10'(({3'h0, expected_dev_mantissa} << expected_dev_exponent));
    wire logic signed [9:0] filt_w = 10'(filt_q);
    wire logic signed [9:0] ext_w = 10'(ext_q);
    wire logic rise = (side_q == FSR_SIDE_LOW) && (filt_w > ext_w + dev);
    wire logic fall = (side_q == FSR_SIDE_HIGH) && (filt_w < ext_w - dev);
    wire logic trans = filt_valid_q && (rise || fall);
    wire logic level_valid = (trans_q == `FSR_MIN_TRANS);
    wire logic averaging = (slicer_average_length != 2'h0);

    // longer length = smaller step = more bits in the running average
    wire logic signed [8:0] lo_err = 9'(ext_q) - 9'(min_avg_q);
    wire logic signed [8:0] hi_err = 9'(ext_q) - 9'(max_avg_q);
    wire logic signed [8:0] lo_step = lo_err >>> slicer_average_length;
    wire logic signed [8:0] hi_step = hi_err >>> slicer_average_length;
    wire fsr_sample_t lo_next = seeded_lo_q ? 8'(9'(min_avg_q) + lo_step) : ext_q;
    wire fsr_sample_t hi_next = seeded_hi_q ? 8'(9'(max_avg_q) + hi_step) : ext_q;

    wire logic signed [8:0] mid_sum = 9'(min_avg_q) + 9'(max_avg_q);
    // before three transitions, or with averaging off, slice about the IF itself
    wire fsr_sample_t slice_level = (level_valid && averaging) ? mid_sum[8:1] : 8'sh0;
    wire logic decision = (filt_q > slice_level);

    always_ff @(posedge clk) begin
        if (reset) begin
            side_q <= FSR_SIDE_LOW;
            ext_q <= '0;
            min_avg_q <= '0;
            max_avg_q <= '0;
            trans_q <= 2'h0;
            seeded_lo_q <= 1'b0;
            seeded_hi_q <= 1'b0;
        end else if (filt_valid_q) begin
            if (trans) begin
                side_q <= rise ? FSR_SIDE_HIGH : FSR_SIDE_LOW;
                ext_q <= filt_q;
                if (!level_valid) trans_q <= trans_q + 2'h1;
                if (rise) begin
                    min_avg_q <= lo_next;
                    seeded_lo_q <= 1'b1;
                end else begin
                    max_avg_q <= hi_next;
                    seeded_hi_q <= 1'b1;
                end
            end else if ((side_q == FSR_SIDE_LOW) ? (filt_q < ext_q) : (filt_q > ext_q)) begin
                ext_q <= filt_q;
            end
        end
    end

    // offset measure: zero until the level is computed
    assign avg_freq = slice_level;

    // bit synchronizer: phase restarts on a decision change, the bit is the
    // majority of the decisions seen since the previous bit end
    logic [15:0] phase_q;
    // wide enough for one bit period of up to 65535 cycles; the vote clears only at a bit end, so relocks can let it wrap
    logic signed [16:0] vote_q;
    logic last_dec_q;
    logic rx_bit_q;
    logic rx_clk_q;

    wire logic dec_change = filt_valid_q && (decision != last_dec_q);
    wire logic bit_end = (phase_q >= baud_q - 16'h1);
    wire logic signed [16:0] vote_step = decision ? 17'sh1 : -17'sh1;
    wire logic signed [16:0] vote_sum = filt_valid_q ? vote_q + vote_step : vote_q;
    wire logic vote_bit = (vote_sum == 17'sh0) ? decision : (vote_sum > 17'sh0);

    always_ff @(posedge clk) begin
        if (reset) begin
            phase_q <= 16'h0;
            vote_q <= '0;
            last_dec_q <= 1'b0;
            rx_bit_q <= 1'b0;
            rx_clk_q <= 1'b0;
        end else begin
            if (filt_valid_q) last_dec_q <= decision;
            if (dec_change || bit_end) begin
                phase_q <= 16'h0;
            end else begin
                phase_q <= phase_q + 16'h1;
            end
            if (bit_end) begin
                rx_bit_q <= vote_bit;
                vote_q <= '0;
            end else begin
                vote_q <= vote_sum;
            end
            // data stable on the rising edge seen by the host
            rx_clk_q <= bit_end ? 1'b0 : (phase_q == (baud_q >> 1)) ? 1'b1 : rx_clk_q;
        end
    end
    assign rx_bit = rx_bit_q;
    assign rx_clk = rx_clk_q;

    // read port: data only in the cycle after the strobe, unmapped reads zero
    wire logic [7:0] status = {5'h0, level_valid, trans_q};
    wire logic [7:0] rd_mux = (addr == `FSR_REG_FREQ_LOW) ? freq_word_low_byte_q :
                              (addr == `FSR_REG_MODEM) ? modem_q :
                              (addr == `FSR_REG_FILTER) ? filter_q :
                              (addr == `FSR_REG_TRACK) ? frequency_tracking_ctrl_q :
                              (addr == `FSR_REG_BAUD_LO) ? baud_q[7:0] :
                              (addr == `FSR_REG_BAUD_HI) ? baud_q[15:8] :
                              (addr == `FSR_REG_AVG_FREQ) ? avg_freq :
                              (addr == `FSR_REG_STATUS) ? status : 8'h00;

    always_ff @(posedge clk) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rd_stb ? rd_mux : 8'h00;
        end
    end
    assign rdata = rdata_q;

    property p_pll_enable_a;
        @(posedge clk) disable iff (reset)
        wr_freq |=> (pll_enable_a == $past(wdata[0]));
    endproperty
    a_pll_enable_a: assert property (p_pll_enable_a) else $error("pll_enable_a bit not applied");

    property p_adc_edge;
        @(posedge clk) disable iff (reset)
        // the edge after a reset may show the clear itself
        $changed(adc_clk_q) && !$past(reset) |-> $past(adc_tick);
    endproperty
    a_adc_edge: assert property (p_adc_edge) else $error("adc clock moved off tick");

    property p_if_quarter;
        @(posedge clk) disable iff (reset)
        $changed(if_clk_q) && !$past(reset) |-> $past(adc_tick && if_cnt_q == 2'h3);
    endproperty
    a_if_quarter: assert property (p_if_quarter) else $error("if clock not adc over four");

    property p_decim;
        @(posedge clk) disable iff (reset)
        filt_valid_q |-> $past(sample_valid && dec_tick);
    endproperty
    a_decim: assert property (p_decim) else $error("filter output off decimation");

    sequence s_rise_seen;
        filt_valid_q && side_q == FSR_SIDE_LOW && rise;
    endsequence
    property p_transition;
        @(posedge clk) disable iff (reset)
        s_rise_seen |=> (side_q == FSR_SIDE_HIGH) && (ext_q == $past(filt_q));
    endproperty
    a_transition: assert property (p_transition) else $error("transition not recorded");

    property p_three_trans;
        @(posedge clk) disable iff (reset)
        (trans_q != 2'h3) |-> (slice_level == 8'sh0);
    endproperty
    a_three_trans: assert property (p_three_trans) else $error("level before three transitions");

    property p_sym;
        @(posedge clk) disable iff (reset)
        (slicer_average_length == 2'h0) |-> (avg_freq == 8'sh0);
    endproperty
    a_sym: assert property (p_sym) else $error("averaging not disabled");

    property p_mean;
        @(posedge clk) disable iff (reset)
        (trans_q == 2'h3 && slicer_average_length != 2'h0) |->
            (2 * int'(avg_freq) - int'(min_avg_q) - int'(max_avg_q)) inside {0, -1};
    endproperty
    a_mean: assert property (p_mean) else $error("level is not the mean");

    property p_lock;
        @(posedge clk) disable iff (reset)
        dec_change |=> (phase_q == 16'h0);
    endproperty
    a_lock: assert property (p_lock) else $error("bit phase did not relock");

    property p_bit;
        @(posedge clk) disable iff (reset)
        bit_end |=> (rx_bit_q == $past(vote_bit)) && !rx_clk_q;
    endproperty
    a_bit: assert property (p_bit) else $error("bit not taken at period end");
endmodule

// ===== pkg/fsr_params.svh
/*
 * Constants of the FSK receive slicer: register indexes, field positions,
 * reset values and divider ratios.
 * Assumes an 8-bit register port where every register sits at its own index.
 */
`ifndef FSR_PARAMS_SVH
`define FSR_PARAMS_SVH

`define FSR_REG_FREQ_LOW 4'h0
`define FSR_REG_MODEM 4'h1
`define FSR_REG_FILTER 4'h2
`define FSR_REG_TRACK 4'h3
`define FSR_REG_BAUD_LO 4'h4
`define FSR_REG_BAUD_HI 4'h5
`define FSR_REG_AVG_FREQ 4'h6
`define FSR_REG_STATUS 4'h7

`define FSR_PLL_ENABLE_A_BIT 0
`define FSR_BYPASS_BIT 7
`define FSR_DEV_EXP_LSB 4
`define FSR_AVG_LEN_LSB 6

`define FSR_FREQ_LOW_RST 8'h00
`define FSR_MODEM_RST 8'h00
`define FSR_FILTER_RST 8'h00
`define FSR_TRACK_RST 8'h00
`define FSR_BAUD_RST 16'h0209

`define FSR_ADC_PER_IF 2'h3
`define FSR_MIN_TRANS 2'h3

`endif

// ===== pkg/fsr_pkg.sv
/*
 * Types of the FSK receive slicer.
 * Assumes nothing beyond the parameter header.
 */
package fsr_pkg;
    typedef logic signed [7:0] fsr_sample_t;
    typedef enum logic {
        FSR_SIDE_LOW = 1'b0,
        FSR_SIDE_HIGH = 1'b1
    } fsr_side_t;
endpackage

// ===== rtl/fsr_tick_div.sv
/*
 * Enabled modulo counter: one tick every (limit + 1) enabled cycles.
 * Assumes a synchronous active-high reset.
 */
`timescale 1ns/1ps
module fsr_tick_div #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic en,
    input wire logic [W-1:0] limit,
    output logic tick
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;
    wire logic at_end = (cnt_q >= limit);

    assign tick = en && at_end;
    assign cnt_d = tick ? '0 : (en ? cnt_q + 1'b1 : cnt_q);

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    property p_tick_gap;
        @(posedge clk) disable iff (reset)
        tick |=> (cnt_q == '0);
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("divider did not restart");
endmodule

// ===== sim/fsr_host_model.sv
/*
 * Host-side model: takes the recovered bit on each rising recovered clock.
 * Assumes rx_bit and rx_clk come from flops in the clk domain.
 */
`timescale 1ns/1ps
module fsr_host_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic rx_bit,
    input wire logic rx_clk,
    output logic [7:0] bit_count,
    output logic [7:0] last_bits
);
    logic rclk_q;
    // sampling mid bit gives the bit the most margin before it changes
    always_ff @(posedge clk) begin
        if (reset) begin
            rclk_q <= 1'b0;
            bit_count <= 8'h00;
            last_bits <= 8'h00;
        end else begin
            rclk_q <= rx_clk;
            if (rx_clk && !rclk_q) begin
                bit_count <= bit_count + 8'h01;
                last_bits <= {last_bits[6:0], rx_bit};
            end
        end
    end
endmodule

// ===== sim/fsr_slicer_tb.sv
/*
 * Self-checking bench of the receive slicer: register port, dividers,
 * decimation, slicing level and recovered bits seen by a host model.
 * Assumes the 32-cycle bit period set here and, except in one pass, the
 * bypassed prefilter.
 */
`timescale 1ns/1ps
`include "fsr_params.svh"
module fsr_slicer_tb;
    import fsr_pkg::*;
    logic clk, reset, wr_stb, rd_stb, sample_valid;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, rd_val, host_count, host_bits;
    fsr_sample_t freq_est, avg_freq;
    logic pll_enable_a, adc_clk, if_clk, prefilter_bypass, rx_bit, rx_clk;
    logic [15:0] baud_rst;
    int err_total, checked;
    fsr_slicer fsr_slicer_i (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .sample_valid(sample_valid),
        .freq_est(freq_est), .pll_enable_a(pll_enable_a), .adc_clk(adc_clk),
        .if_clk(if_clk), .prefilter_bypass(prefilter_bypass), .rx_bit(rx_bit),
        .rx_clk(rx_clk), .avg_freq(avg_freq));
    fsr_host_model fsr_host_model_i (.clk(clk), .reset(reset), .rx_bit(rx_bit),
        .rx_clk(rx_clk), .bit_count(host_count), .last_bits(host_bits));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 rd_val = rdata;
    endtask
    task automatic do_reset();
        @(posedge clk);
        reset <= 1'b1;
        // stale samples would be sliced before setup has written the thresholds
        sample_valid <= 1'b0;
        freq_est <= 8'sd0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
    endtask
    // bit period of 32 cycles, prefilter bypassed so samples reach the filter unchanged
    task automatic setup(input logic [2:0] dec, input logic [7:0] track);
        wr(`FSR_REG_BAUD_LO, 8'h20);
        wr(`FSR_REG_BAUD_HI, 8'h00);
        wr(`FSR_REG_FILTER, {5'h10, dec});
        wr(`FSR_REG_TRACK, track);
    endtask
    task automatic send(input logic [7:0] pat, input int n, input int hi, input int lo);
        for (int i = n - 1; i >= 0; i--) begin
            repeat (32) begin
                @(posedge clk);
                sample_valid <= 1'b1;
                freq_est <= fsr_sample_t'(pat[i] ? hi : lo);
            end
        end
    endtask
    task automatic period(input bit sel, output int p);
        logic prev, cur;
        int edges;
        edges = 0;
        p = 0;
        prev = sel ? if_clk : adc_clk;
        for (int k = 0; k < 300 && edges < 2; k++) begin
            @(posedge clk);
            #1 cur = sel ? if_clk : adc_clk;
            if (cur && !prev) edges++;
            if (edges == 1) p++;
            prev = cur;
        end
        if (edges < 2) begin
            err_total++;
            complete_run();
        end
    endtask
    task automatic t_reset();
        for (int i = 0; i < 6; i++) begin
            rd(i[3:0]);
            chk("reset value", rd_val, (i == 4) ? baud_rst[7:0] : (i == 5) ? baud_rst[15:8] : 8'h00);
        end
        @(posedge clk);
        #1 chk("rdata after read", rdata, 8'h00);
        wr(4'h6, 8'h5a);
        rd(4'h6);
        chk("read-only offset", rd_val, 8'h00);
        rd(4'h9);
        chk("unmapped read", rd_val, 8'h00);
        chk("outputs at reset", {pll_enable_a, prefilter_bypass, rx_bit, avg_freq}, 16'h0000);
    endtask
    task automatic t_regs();
        wr(`FSR_REG_FREQ_LOW, 8'h01);
        wr(`FSR_REG_FILTER, 8'h80);
        #1 chk("pll_enable_a on", pll_enable_a, 1'b1);
        chk("bypass on", prefilter_bypass, 1'b1);
        wr(`FSR_REG_FREQ_LOW, 8'hfe);
        rd(`FSR_REG_FREQ_LOW);
        chk("freq low readback", rd_val, 8'hfe);
        chk("pll_enable_a off", pll_enable_a, 1'b0);
    endtask
    task automatic t_clocks();
        int p_if, p_adc;
        for (int n = 0; n < 8; n += 3) begin
            wr(`FSR_REG_MODEM, n[7:0]);
            repeat (80) @(posedge clk);
            period(1'b1, p_if);
            period(1'b0, p_adc);
            chk("if period", p_if, 8 * (n + 1));
            chk("adc per if", p_if, 4 * p_adc);
        end
    endtask
    task automatic t_slicer();
        logic [7:0] c0;
        do_reset();
        setup(3'h0, 8'h64);
        send(8'h01, 2, 50, -30);
        rd(`FSR_REG_STATUS);
        chk("level valid early", rd_val[2], 1'b0);
        chk("level early", avg_freq, 8'h00);
        send(8'h15, 6, 50, -30);
        rd(`FSR_REG_STATUS);
        chk("level valid", rd_val[2], 1'b1);
        chk("decision level", avg_freq, 8'h0a);
        rd(`FSR_REG_AVG_FREQ);
        chk("offset register", rd_val, 8'h0a);
        c0 = host_count;
        send(8'hff, 8, 50, -30);
        chk("bits per period", (host_count - c0) inside {[7:9]}, 1'b1);
        chk("steady one", {rx_bit, host_bits[3:0]}, 5'h1f);
        send(8'h00, 8, 50, -30);
        chk("steady zero", {rx_bit, host_bits[3:0]}, 5'h00);
        send(8'h55, 8, 70, -10);
        chk("level follows", avg_freq > 10 && avg_freq <= 30, 1'b1);
        wr(`FSR_REG_TRACK, 8'h24);
        send(8'hff, 4, 70, -10);
        send(8'hff, 8, 5, -10);
        chk("symmetric level", avg_freq, 8'h00);
        chk("above centre", rx_bit, 1'b1);
    endtask
    task automatic t_dev();
        do_reset();
        setup(3'h0, 8'h7f);
        send(8'h15, 6, 40, -40);
        rd(`FSR_REG_STATUS);
        chk("small swing ignored", rd_val[2:0], 3'h0);
    endtask
    // alternating samples cancel within every even box, so no transition is seen
    task automatic t_dec();
        for (int d = 1; d < 8; d += 2) begin
            do_reset();
            setup(d[2:0], 8'h64);
            repeat (256) begin
                @(posedge clk);
                sample_valid <= 1'b1;
                freq_est <= (freq_est == 8'sd50) ? -8'sd30 : 8'sd50;
            end
            rd(`FSR_REG_STATUS);
            chk("box averaged", rd_val[2], 1'b0);
        end
        // prefilter in circuit: the pair average cancels the alternation as well
        do_reset();
        wr(`FSR_REG_TRACK, 8'h64);
        chk("bypass off", prefilter_bypass, 1'b0);
        repeat (64) begin
            @(posedge clk);
            sample_valid <= 1'b1;
            freq_est <= (freq_est == 8'sd50) ? -8'sd30 : 8'sd50;
        end
        rd(`FSR_REG_STATUS);
        chk("pair averaged", rd_val[2], 1'b0);
    endtask
    initial begin
        reset = 1'b1;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        sample_valid = 1'b0;
        freq_est = 8'sd0;
        baud_rst = `FSR_BAUD_RST;
        err_total = 0;
        checked = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        t_reset();
        t_regs();
        t_clocks();
        t_slicer();
        t_dev();
        t_dec();
        complete_run();
    end
endmodule
